// ### lsu_shift_core.sv
// Purpose: logic shift datapath and shared constants of the logical shift unit
// Assumes: operands come from registers on the same clock; purely combinational
// Notes: the package sits ahead of the datapath so one file compiles first

`timescale 1ns/1ps

package lsu_pkg;
  // register byte offsets
  localparam logic [7:0] LSU_OFF_SUM = 8'h00;
  localparam logic [7:0] LSU_OFF_MUL = 8'h04;
  localparam logic [7:0] LSU_OFF_MCAND = 8'h08;
  localparam logic [7:0] LSU_OFF_STAT = 8'h0C;
  localparam logic [7:0] LSU_OFF_RPT = 8'h10;
  localparam logic [7:0] LSU_OFF_CMD = 8'h14;
  // status field positions
  localparam int LSU_ST_C = 0;
  localparam int LSU_ST_N = 1;
  localparam int LSU_ST_Z = 2;
  localparam int LSU_ST_V = 3;
  localparam int LSU_ST_OVC_LO = 4;
  localparam int LSU_ST_OVC_HI = 9;
  // command field positions
  localparam int LSU_CMD_OP_LO = 0;
  localparam int LSU_CMD_OP_HI = 2;
  localparam int LSU_CMD_HALF = 3;
  localparam int LSU_CMD_IMM_LO = 4;
  localparam int LSU_CMD_IMM_HI = 7;
  // operation codes
  localparam logic [2:0] LSU_OP_NONE = 3'h0;
  localparam logic [2:0] LSU_OP_SHL_WIDE = 3'h1;
  localparam logic [2:0] LSU_OP_SHL_LONG = 3'h2;
  localparam logic [2:0] LSU_OP_SHR_HALF_IMM = 3'h3;
  localparam logic [2:0] LSU_OP_SHR_HALF_REG = 3'h4;
  localparam logic [2:0] LSU_OP_SHR_WIDE = 3'h5;
  // reset values and bus answers
  localparam logic [31:0] LSU_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] LSU_RST_RPT = 8'h00;
  localparam logic [1:0] LSU_RESP_OKAY = 2'h0;
  localparam logic [1:0] LSU_RESP_SLVERR = 2'h2;
endpackage : lsu_pkg

module lsu_shift_core
  import lsu_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic half_upper,
  input wire logic [3:0] imm_field,
  input wire logic [31:0] acc_in,
  input wire logic [31:0] p_in,
  input wire logic [15:0] t_in,
  output logic [31:0] acc_out,
  output logic [31:0] p_out,
  output logic carry_out,
  output logic neg_out,
  output logic zero_out,
  output logic op_ok
);
  logic [4:0] imm_cnt;
  logic [4:0] half_cnt;
  logic [15:0] half_in;
  logic [16:0] half_sh;
  logic [64:0] wide_l;
  logic [64:0] wide_r;
  logic [32:0] long_l;

  // immediate field encodes counts 1..16, so a zero count never occurs there
  assign imm_cnt = {1'b0, imm_field} + 5'h01;
  assign half_in = half_upper ? acc_in[31:16] : acc_in[15:0];
  assign half_cnt = (op == LSU_OP_SHR_HALF_IMM) ? imm_cnt : {1'b0, t_in[3:0]};
  // one spare bit on each shifter catches the last bit shifted out
  assign half_sh = {half_in, 1'b0} >> half_cnt;
  assign wide_l = {1'b0, acc_in, p_in} << t_in[5:0];
  assign wide_r = {acc_in, p_in, 1'b0} >> imm_cnt;
  assign long_l = {1'b0, acc_in} << t_in[4:0];

  // result and flag select per operation
  always_comb begin
    acc_out = acc_in;
    p_out = p_in;
    carry_out = 1'b0;
    neg_out = 1'b0;
    zero_out = 1'b0;
    op_ok = 1'b1;
    case (op)
      LSU_OP_SHL_WIDE: begin
        {acc_out, p_out} = wide_l[63:0];
        carry_out = (t_in[5:0] == 6'h00) ? 1'b0 : wide_l[64];
      end
      LSU_OP_SHR_WIDE: begin
        {acc_out, p_out} = wide_r[64:1];
        carry_out = wide_r[0];
      end
      LSU_OP_SHL_LONG: begin
        acc_out = long_l[31:0];
        carry_out = (t_in[4:0] == 5'h00) ? 1'b0 : long_l[32];
      end
      LSU_OP_SHR_HALF_IMM, LSU_OP_SHR_HALF_REG: begin
        if (half_upper) begin
          acc_out = {half_sh[16:1], acc_in[15:0]};
        end else begin
          acc_out = {acc_in[31:16], half_sh[16:1]};
        end
        carry_out = (half_cnt == 5'h00) ? 1'b0 : half_sh[0];
      end
      default: begin
        op_ok = 1'b0;
      end
    endcase
    // flags follow the width of the operand that was shifted
    if (op == LSU_OP_SHR_HALF_IMM || op == LSU_OP_SHR_HALF_REG) begin
      neg_out = half_sh[16];
      zero_out = (half_sh[16:1] == 16'h0000);
    end else if (op == LSU_OP_SHL_LONG) begin
      neg_out = acc_out[31];
      zero_out = (acc_out == 32'h0000_0000);
    end else begin
      neg_out = acc_out[31];
      zero_out = ({acc_out, p_out} == 64'h0000_0000_0000_0000);
    end
  end
endmodule : lsu_shift_core

// ### lsu_logical_shift_unit.sv
// Purpose: logical shift unit with AXI4-Lite register access
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes: a command register write with a shift code (1..5) runs one shift on the next edge
// Summary of operation
// - wide left shift by operand_hi_word low six bits, zero filled
// - wide pair is sum_register high word over mul_result low word
// - after wide shift, msb_flag copies sum_register bit 31
// - after wide shift, all_clear_flag set only when whole pair is zero
// - register count zero clears spill_flag, else last bit out
// - long left shift by low five count bits, zero filled
// - long shift updates zero and msb flags even at count zero
// - half right shift by immediate 1..16, zero filled, last bit to spill
// - only the chosen upper or low half of sum_register changes
// - after half shift, msb_flag copies result bit 15
// - after half shift, all_clear_flag set when half result is zero
// - half right by register uses low four count bits, flags always updated
// - wide right shift by immediate 1..16, zero filled, last bit to spill
// - register count source is upper 16 bits of multiplicand_register
// - shifts are not repeated; repeat_counter clears and shift runs once
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.

`timescale 1ns/1ps

module lsu_logical_shift_unit
  import lsu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [31:0] sum_r, sum_nxt, mul_r, mul_nxt, mcand_r, mcand_nxt, cmd_r, cmd_nxt;
  logic [9:0] stat_r, stat_nxt;
  logic [7:0] rpt_r, rpt_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_go, exec;
  logic [31:0] cmd_new, sh_acc, sh_p;
  logic sh_c, sh_n, sh_z, sh_ok;

  // byte-lane merge used for every writable register
  function automatic logic [31:0] lsu_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lsu_merge

  // address check shared by both read and write paths
  function automatic logic lsu_mapped(input logic [7:0] addr);
    return (addr == LSU_OFF_SUM) || (addr == LSU_OFF_MUL) || (addr == LSU_OFF_MCAND) ||
           (addr == LSU_OFF_STAT) || (addr == LSU_OFF_RPT) || (addr == LSU_OFF_CMD);
  endfunction : lsu_mapped

  // write fires once both address and data are held and no response is pending
  assign wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign cmd_new = lsu_merge(cmd_r, wdata_r, wstrb_r);
  assign exec = wr_go && (awaddr_r == LSU_OFF_CMD) && sh_ok;
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  lsu_shift_core u_core (
    .op(cmd_new[LSU_CMD_OP_HI:LSU_CMD_OP_LO]),
    .half_upper(cmd_new[LSU_CMD_HALF]),
    .imm_field(cmd_new[LSU_CMD_IMM_HI:LSU_CMD_IMM_LO]),
    .acc_in(sum_r),
    .p_in(mul_r),
    .t_in(mcand_r[31:16]),
    .acc_out(sh_acc),
    .p_out(sh_p),
    .carry_out(sh_c),
    .neg_out(sh_n),
    .zero_out(sh_z),
    .op_ok(sh_ok)
  );

  // bus channel next state
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = lsu_mapped(awaddr_r) ? LSU_RESP_OKAY : LSU_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = lsu_mapped(s_axi_araddr) ? LSU_RESP_OKAY : LSU_RESP_SLVERR;
      unique case (s_axi_araddr)
        LSU_OFF_SUM: rdata_nxt = sum_r;
        LSU_OFF_MUL: rdata_nxt = mul_r;
        LSU_OFF_MCAND: rdata_nxt = mcand_r;
        LSU_OFF_STAT: rdata_nxt = {22'h00_0000, stat_r};
        LSU_OFF_RPT: rdata_nxt = {24'h00_0000, rpt_r};
        LSU_OFF_CMD: rdata_nxt = cmd_r;
        default: rdata_nxt = LSU_RST_WORD;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= LSU_RST_WORD;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= LSU_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= LSU_RST_WORD;
      rresp_r <= LSU_RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // register file and shift commit; a shift owns the operand registers that cycle
  always_comb begin
    sum_nxt = sum_r;
    mul_nxt = mul_r;
    mcand_nxt = mcand_r;
    stat_nxt = stat_r;
    rpt_nxt = rpt_r;
    cmd_nxt = cmd_r;
    if (wr_go) begin
      unique case (awaddr_r)
        LSU_OFF_SUM: sum_nxt = lsu_merge(sum_r, wdata_r, wstrb_r);
        LSU_OFF_MUL: mul_nxt = lsu_merge(mul_r, wdata_r, wstrb_r);
        LSU_OFF_MCAND: mcand_nxt = lsu_merge(mcand_r, wdata_r, wstrb_r);
        LSU_OFF_STAT: stat_nxt = 10'(lsu_merge({22'h00_0000, stat_r}, wdata_r, wstrb_r));
        LSU_OFF_RPT: rpt_nxt = 8'(lsu_merge({24'h00_0000, rpt_r}, wdata_r, wstrb_r));
        LSU_OFF_CMD: cmd_nxt = cmd_new;
        default: cmd_nxt = cmd_r;
      endcase
    end
    if (exec) begin
      sum_nxt = sh_acc;
      mul_nxt = sh_p;
      stat_nxt[LSU_ST_C] = sh_c;
      stat_nxt[LSU_ST_N] = sh_n;
      stat_nxt[LSU_ST_Z] = sh_z;
      rpt_nxt = LSU_RST_RPT;
    end
  end

  // overflow bits only ever come from software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_r <= LSU_RST_WORD;
      mul_r <= LSU_RST_WORD;
      mcand_r <= LSU_RST_WORD;
      stat_r <= 10'h000;
      rpt_r <= LSU_RST_RPT;
      cmd_r <= LSU_RST_WORD;
    end else begin
      sum_r <= sum_nxt;
      mul_r <= mul_nxt;
      mcand_r <= mcand_nxt;
      stat_r <= stat_nxt;
      rpt_r <= rpt_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // checks; op decoded from the command that executes
  logic [2:0] x_op;
  logic x_up;
  assign x_op = cmd_new[LSU_CMD_OP_HI:LSU_CMD_OP_LO];
  assign x_up = cmd_new[LSU_CMD_HALF];

  property p_rpt_clear;
    @(posedge aclk) disable iff (!aresetn) exec |=> rpt_r == 8'h00;
  endproperty
  a_rpt_clear: assert property (p_rpt_clear) else $error("repeat counter not cleared");

  property p_ovf_keep;
    @(posedge aclk) disable iff (!aresetn) exec |=> $stable(stat_r[LSU_ST_OVC_HI:LSU_ST_V]);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow state changed by shift");

  property p_wide_neg;
    @(posedge aclk) disable iff (!aresetn)
      exec && (x_op == LSU_OP_SHL_WIDE || x_op == LSU_OP_SHR_WIDE) |=> stat_r[LSU_ST_N] == sum_r[31];
  endproperty
  a_wide_neg: assert property (p_wide_neg) else $error("wide msb flag wrong");

  property p_wide_zero;
    @(posedge aclk) disable iff (!aresetn)
      exec && (x_op == LSU_OP_SHL_WIDE || x_op == LSU_OP_SHR_WIDE)
      |=> stat_r[LSU_ST_Z] == ({sum_r, mul_r} == 64'h0000_0000_0000_0000);
  endproperty
  a_wide_zero: assert property (p_wide_zero) else $error("wide zero flag wrong");

  property p_zero_count;
    @(posedge aclk) disable iff (!aresetn)
      exec && (x_op == LSU_OP_SHL_WIDE || x_op == LSU_OP_SHL_LONG) && mcand_r[20:16] == 5'h00
      && (x_op == LSU_OP_SHL_LONG || !mcand_r[21])
      |=> !stat_r[LSU_ST_C] && sum_r == $past(sum_r) && mul_r == $past(mul_r);
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count changed data or carry");

  property p_half_only;
    @(posedge aclk) disable iff (!aresetn)
      exec && (x_op == LSU_OP_SHR_HALF_IMM || x_op == LSU_OP_SHR_HALF_REG) && x_up
      |=> sum_r[15:0] == $past(sum_r[15:0]) && $stable(mul_r) && stat_r[LSU_ST_N] == sum_r[31]
          && stat_r[LSU_ST_Z] == (sum_r[31:16] == 16'h0000);
  endproperty
  a_half_only: assert property (p_half_only) else $error("upper half shift wrong");

  property p_half_low;
    @(posedge aclk) disable iff (!aresetn)
      exec && x_op == LSU_OP_SHR_HALF_IMM && !x_up
      |=> sum_r[31:16] == $past(sum_r[31:16]) && !sum_r[15] && !stat_r[LSU_ST_N];
  endproperty
  a_half_low: assert property (p_half_low) else $error("low half immediate shift wrong");

  property p_wide_right_fill;
    @(posedge aclk) disable iff (!aresetn)
      exec && x_op == LSU_OP_SHR_WIDE |=> !sum_r[31] && !stat_r[LSU_ST_N];
  endproperty
  a_wide_right_fill: assert property (p_wide_right_fill) else $error("wide right not zero filled");

  property p_long_flags;
    @(posedge aclk) disable iff (!aresetn)
      exec && x_op == LSU_OP_SHL_LONG |=> stat_r[LSU_ST_Z] == (sum_r == 32'h0000_0000) && $stable(mul_r);
  endproperty
  a_long_flags: assert property (p_long_flags) else $error("long shift flags wrong");

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  c_wide: cover property (@(posedge aclk) disable iff (!aresetn) exec && x_op == LSU_OP_SHL_WIDE);
  c_half: cover property (@(posedge aclk) disable iff (!aresetn) exec && x_op == LSU_OP_SHR_HALF_REG);
  c_rpt: cover property (@(posedge aclk) disable iff (!aresetn) exec && rpt_r != 8'h00);
  c_err: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rresp == LSU_RESP_SLVERR);
endmodule : lsu_logical_shift_unit

// ### tb_top.sv
// Purpose: self-checking bench for the logical shift unit over its register bus
// Assumes: AXI4-Lite slave, one write and one read at a time; single clock
// Notes: random operands from a fixed seed, corner counts on the first passes

`timescale 1ns/1ps

module tb_top;
  import lsu_pkg::*;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  integer seed = 32'h69a14142;
  int fails = 0;
  int n_compared = 0;

  lsu_logical_shift_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // free running core clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // both channels offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp;
    if (k == 64) begin
      fails++;
      print_verdict();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp;
    if (k == 64) begin
      fails++;
      print_verdict();
    end
  endtask : axi_rd

  // reference shifter; flags come back as {zero, msb, spill}
  function automatic void model(input logic [2:0] op, input logic hu, input logic [3:0] imm, input logic [31:0] s,
                                input logic [31:0] m, input logic [15:0] t, output logic [31:0] es,
                                output logic [31:0] em, output logic [2:0] f);
    logic [64:0] w;
    logic [16:0] hw;
    logic [15:0] h;
    int c;
    es = s;
    em = m;
    f = 3'h0;
    h = hu ? s[31:16] : s[15:0];
    case (op)
      LSU_OP_SHL_WIDE: begin
        w = {1'b0, s, m} << t[5:0];
        {es, em} = w[63:0];
        f = {w[63:0] == 64'h0, w[63], w[64]};
      end
      LSU_OP_SHL_LONG: begin
        w = {33'h0, s} << t[4:0];
        es = w[31:0];
        f = {es == 32'h0, es[31], w[32]};
      end
      LSU_OP_SHR_WIDE: begin
        c = imm + 1;
        w = {s, m, 1'b0} >> c;
        {es, em} = w[64:1];
        f = {w[64:1] == 64'h0, w[64], w[0]};
      end
      default: begin
        c = (op == LSU_OP_SHR_HALF_IMM) ? imm + 1 : t[3:0];
        hw = {h, 1'b0} >> c;
        if (hu) es[31:16] = hw[16:1];
        else es[15:0] = hw[16:1];
        f = {hw[16:1] == 16'h0, hw[16], hw[0]};
      end
    endcase
  endfunction : model

  initial begin
    logic [31:0] s, m, x, st, cmd, es, em, d;
    logic [2:0] f;
    logic [1:0] r;
    int i;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values of every register
    for (i = 0; i < 6; i++) begin
      axi_rd(8'(i * 4), d, r);
      check(d, LSU_RST_WORD, "reset value");
    end
    // byte strobes merge into the old word
    axi_wr(LSU_OFF_SUM, 32'hFFFF_FFFF, 4'hF, r);
    axi_wr(LSU_OFF_SUM, 32'h1234_5678, 4'h5, r);
    axi_rd(LSU_OFF_SUM, d, r);
    check(d, 32'hFF34_FF78, "strobed write");
    // unmapped places answer with an error and change nothing
    axi_wr(8'h1C, 32'h0000_0001, 4'hF, r);
    check(32'(r), 32'(LSU_RESP_SLVERR), "unmapped write resp");
    axi_rd(8'h18, d, r);
    check(d, 32'h0000_0000, "unmapped read data");
    check(32'(r), 32'(LSU_RESP_SLVERR), "unmapped read resp");
    axi_rd(LSU_OFF_SUM, d, r);
    check(d, 32'hFF34_FF78, "unmapped write effect");
    // every shift code; passes 0..4, 5..9 and 10..14 are the minimum count, maximum count and zero operand corners
    for (i = 0; i < 80; i++) begin
      s = $random(seed);
      m = $random(seed);
      x = $random(seed);
      st = $random(seed);
      cmd = $random(seed);
      cmd[2:0] = 3'(1 + i % 5);
      if (i < 5) begin
        x[31:16] = 16'hFFC0;
        cmd[7:4] = 4'h0;
      end else if (i < 10) begin
        x[31:16] = 16'hFFFF;
        cmd[7:4] = 4'hF;
      end else if (i < 15) begin
        s = 32'h0000_0000;
        m = 32'h0000_0000;
      end
      axi_wr(LSU_OFF_SUM, s, 4'hF, r);
      axi_wr(LSU_OFF_MUL, m, 4'hF, r);
      axi_wr(LSU_OFF_MCAND, x, 4'hF, r);
      axi_wr(LSU_OFF_STAT, st, 4'hF, r);
      axi_wr(LSU_OFF_RPT, 32'(8'h01 | 8'($random(seed))), 4'hF, r);
      axi_rd(LSU_OFF_STAT, d, r);
      check(d, st & 32'h0000_03FF, "status readback");
      axi_wr(LSU_OFF_CMD, cmd, 4'hF, r);
      check(32'(r), 32'(LSU_RESP_OKAY), "command resp");
      model(cmd[2:0], cmd[3], cmd[7:4], s, m, x[31:16], es, em, f);
      axi_rd(LSU_OFF_SUM, d, r);
      check(d, es, "sum_register");
      axi_rd(LSU_OFF_MUL, d, r);
      check(d, em, "mul_result");
      axi_rd(LSU_OFF_STAT, d, r);
      check(d & 32'h0000_0007, 32'(f), "shift flags");
      check(d & 32'hFFFF_FFF8, st & 32'h0000_03F8, "overflow bits");
      axi_rd(LSU_OFF_RPT, d, r);
      check(d, 32'h0000_0000, "repeat counter");
    end
    // codes with no shift store the command and leave data and repeat count alone
    for (i = 0; i < 3; i++) begin
      cmd = (i == 0) ? 32'h0000_0000 : 32'(5 + i);
      axi_wr(LSU_OFF_SUM, 32'hA5A5_0F0F, 4'hF, r);
      axi_wr(LSU_OFF_RPT, 32'h0000_0005, 4'hF, r);
      axi_wr(LSU_OFF_CMD, cmd, 4'hF, r);
      axi_rd(LSU_OFF_SUM, d, r);
      check(d, 32'hA5A5_0F0F, "no-op sum");
      axi_rd(LSU_OFF_RPT, d, r);
      check(d, 32'h0000_0005, "no-op repeat counter");
      axi_rd(LSU_OFF_CMD, d, r);
      check(d, cmd, "command readback");
    end
    // reset in mid-run returns the registers to zero
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(LSU_OFF_SUM, d, r);
    check(d, LSU_RST_WORD, "sum after reset");
    axi_rd(LSU_OFF_RPT, d, r);
    check(d, LSU_RST_WORD, "repeat counter after reset");
    print_verdict();
  end

  // whole-run guard against a stuck bus
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    print_verdict();
  end
endmodule : tb_top
